/* File: rtl/astrc_pkg.sv */
// Constants, register map and bus carrier for the asynchronous serial core.
// Assumes a single 100 MHz bus clock and an 8-bit register port.
// Operation
// - Data address reads receive, writes transmit buffer
// - Data accesses complete the status flag clear sequences
// - One bus-clocked baud generator serves both directions
// - Receiver realigns bit timing on falling edges
// - Transmit idles high; polarity flip inverts everything
// - Enabling transmitter queues one idle preamble frame
// - Shifter holds ten bits, eleven in nine-bit mode
// - Free shifter takes buffer on tick, sets vacant
// - Nothing waiting after stop sets all-done, idles
// - Disabling holds pin until current frame, queued idle and break finish
// - Queue-break write one then zero sends one break
// - Break still requested at load queues another
// - Break is 10, 11, 13 or 14 bits
// - Disable then enable queues one idle character
// - Receive polarity flip; receiver runs only when enabled
// - Frame is start zero, data LSB first, stop one
// - Complete character loads buffer only when empty
// - Character into full buffer sets overrun, discarded
// - Buffer-full flag clears only by access sequence
// - Clear is status-one read then data read
// - Sixteen slots per bit, vote 8-10, noise
// - Start edge after three ones, confirmed at 3,5,7
`default_nettype none
package astrc_pkg;
   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [2:0] ADDR_BAUD_HI = 3'h0;
   localparam logic [2:0] ADDR_BAUD_LO = 3'h1;
   localparam logic [2:0] ADDR_CTRL1 = 3'h2;
   localparam logic [2:0] ADDR_CTRL2 = 3'h3;
   localparam logic [2:0] ADDR_STAT1 = 3'h4;
   localparam logic [2:0] ADDR_STAT2 = 3'h5;
   localparam logic [2:0] ADDR_CTRL3 = 3'h6;
   localparam logic [2:0] ADDR_DATA = 3'h7;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int CTRL1_NINE_BIT = 4;
   localparam int CTRL2_TX_EN = 3;
   localparam int CTRL2_RX_EN = 2;
   localparam int CTRL2_QBRK = 0;
   localparam int STAT1_TX_BUFFER_VACANT = 7;
   localparam int STAT1_TC = 6;
   localparam int STAT1_RX_BUFFER_FULL = 5;
   localparam int STAT1_OVR = 3;
   localparam int STAT1_NF = 2;
   localparam int STAT1_FE = 1;
   localparam int STAT2_RX_FLIP = 4;
   localparam int STAT2_LONG_BRK = 2;
   localparam int STAT2_RX_ACTIVE = 0;
   localparam int CTRL3_R8 = 7;
   localparam int CTRL3_T8 = 6;
   localparam int CTRL3_TX_FLIP = 4;
   // ------------------------------------------------------------
   // Reset values and counts
   // ------------------------------------------------------------
   localparam logic [12:0] BAUD_MOD_RESET = 13'h0004;
   localparam logic [3:0] FRAME_BITS_8 = 4'ha;
   localparam logic [3:0] FRAME_BITS_9 = 4'hb;
   localparam logic [3:0] LONG_BRK_EXTRA = 4'h3;
   localparam logic [3:0] STOP_IDX_8 = 4'h9;
   localparam logic [3:0] STOP_IDX_9 = 4'ha;
   localparam logic [3:0] TX_TICK_LAST = 4'hf;
   localparam logic [4:0] SLOT_FIRST = 5'h01;
   localparam logic [4:0] SLOT_START_A = 5'h03;
   localparam logic [4:0] SLOT_START_B = 5'h05;
   localparam logic [4:0] SLOT_START_C = 5'h07;
   localparam logic [4:0] SLOT_VOTE_A = 5'h08;
   localparam logic [4:0] SLOT_VOTE_B = 5'h09;
   localparam logic [4:0] SLOT_VOTE_C = 5'h0a;
   localparam logic [4:0] SLOT_LATE_EDGE = 5'h0b;
   localparam logic [4:0] SLOT_LAST = 5'h10;
   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } astrc_bus_req_t;
   typedef enum logic [1:0] {RX_HUNT, RX_START, RX_FRAME} astrc_rx_state_t;
endpackage
`default_nettype wire

/* File: rtl/astrc_baud.sv */
// Baud tick generator: bus clock divided by a programmable modulo.
// Assumes the modulo is written while the link is quiet.
`timescale 1ns/1ps
`default_nettype none
module astrc_baud (
   input wire logic clk, // Bus clock
   input wire logic rst_n, // Synchronised reset, active low
   input wire logic [12:0] modulo, // Divide value, zero stops the tick
   output var logic tick // Sixteen-times sample tick, one cycle
);
   import astrc_pkg::*;
   logic [12:0] cnt_r;
   // ------------------------------------------------------------
   // Divider
   // ------------------------------------------------------------
   // Counts 1..modulo so the tick period equals the modulo exactly
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_r <= 13'h0001;
         tick <= 1'b0;
      end
      else if (modulo == 13'h0000)
      begin
         cnt_r <= 13'h0001;
         tick <= 1'b0;
      end
      else if (cnt_r >= modulo)
      begin
         cnt_r <= 13'h0001;
         tick <= 1'b1;
      end
      else
      begin
         cnt_r <= cnt_r + 13'h0001;
         tick <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: rtl/astrc_core.sv */
// Asynchronous serial transmitter and receiver with register port.
// Assumes rxd is already synchronous to clk; bus strobes are one cycle.
`timescale 1ns/1ps
`default_nettype none
module astrc_core (
   input wire logic clk, // 100 MHz bus clock
   input wire logic resetn, // Asynchronous reset, active low
   input wire astrc_pkg::astrc_bus_req_t bus_req, // Register request
   output var logic [7:0] rd_data, // Read data, cycle after read strobe
   input wire logic rxd, // Serial receive line
   output var logic txd, // Serial transmit line
   output var logic tx_oe, // High while transmitter owns the pin
   output var logic rx_active // High while a frame is being received
);
   import astrc_pkg::*;
   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   logic rst_meta_r, rst_n_r;
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rst_meta_r <= 1'b0;
         rst_n_r <= 1'b0;
      end
      else
      begin
         rst_meta_r <= 1'b1;
         rst_n_r <= rst_meta_r;
      end
   end
   // ------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------
   logic [12:0] baud_mod_r;
   logic nine_bit_r, tx_en_r, rx_en_r, qbrk_r, long_brk_r, rx_flip_r, tx_flip_r, t8_r;
   logic wr_ctrl2, wr_data, rd_stat1, rd_dport;
   assign wr_ctrl2 = bus_req.wr && (bus_req.addr == ADDR_CTRL2);
   assign wr_data = bus_req.wr && (bus_req.addr == ADDR_DATA);
   assign rd_stat1 = bus_req.rd && (bus_req.addr == ADDR_STAT1);
   assign rd_dport = bus_req.rd && (bus_req.addr == ADDR_DATA);
   // Plain storage written by software
   always_ff @(posedge clk or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         baud_mod_r <= BAUD_MOD_RESET;
         nine_bit_r <= 1'b0;
         tx_en_r <= 1'b0;
         rx_en_r <= 1'b0;
         qbrk_r <= 1'b0;
         long_brk_r <= 1'b0;
         rx_flip_r <= 1'b0;
         tx_flip_r <= 1'b0;
         t8_r <= 1'b0;
      end
      else if (bus_req.wr)
      begin
         unique case (bus_req.addr)
            ADDR_BAUD_HI: baud_mod_r[12:8] <= bus_req.wdata[4:0];
            ADDR_BAUD_LO: baud_mod_r[7:0] <= bus_req.wdata;
            ADDR_CTRL1: nine_bit_r <= bus_req.wdata[CTRL1_NINE_BIT];
            ADDR_CTRL2:
            begin
               tx_en_r <= bus_req.wdata[CTRL2_TX_EN];
               rx_en_r <= bus_req.wdata[CTRL2_RX_EN];
               qbrk_r <= bus_req.wdata[CTRL2_QBRK];
            end
            ADDR_STAT2:
            begin
               rx_flip_r <= bus_req.wdata[STAT2_RX_FLIP];
               long_brk_r <= bus_req.wdata[STAT2_LONG_BRK];
            end
            ADDR_CTRL3:
            begin
               t8_r <= bus_req.wdata[CTRL3_T8];
               tx_flip_r <= bus_req.wdata[CTRL3_TX_FLIP];
            end
            default: ;
         endcase
      end
   end
   // ------------------------------------------------------------
   // Shared baud generator
   // ------------------------------------------------------------
   logic tick16;
   // Both directions count the same tick, otherwise they run apart
   astrc_baud u_baud (
      .clk(clk),
      .rst_n(rst_n_r),
      .modulo(baud_mod_r),
      .tick(tick16)
   );
   // ------------------------------------------------------------
   // Transmitter
   // ------------------------------------------------------------
   logic [7:0] tx_buf_r;
   logic [10:0] shreg_r;
   logic [3:0] tx_sub_r, tx_bits_r, frame_len, brk_len;
   logic tx_busy_r, tx_brk_r, idle_pend_r, brk_pend_r, tx_buffer_vacant_r, tc_r, tx_arm_r;
   logic tx_slot, load_idle, load_brk, load_data, tx_last_end;
   assign frame_len = nine_bit_r ? FRAME_BITS_9 : FRAME_BITS_8;
   assign brk_len = frame_len + (long_brk_r ? LONG_BRK_EXTRA : 4'h0);
   // Loads happen only on a baud tick with the shifter free
   assign tx_slot = tick16 && !tx_busy_r;
   assign load_idle = tx_slot && idle_pend_r;
   assign load_brk = tx_slot && !idle_pend_r && brk_pend_r;
   assign load_data = tx_slot && !idle_pend_r && !brk_pend_r && !tx_buffer_vacant_r && tx_en_r;
   assign tx_last_end = tx_busy_r && tick16 && (tx_sub_r == TX_TICK_LAST) && (tx_bits_r == 4'h1);
   // Transmit buffer, written through the shared data address
   always_ff @(posedge clk or negedge rst_n_r)
   begin
      if (!rst_n_r)
         tx_buf_r <= 8'h00;
      else if (wr_data)
         tx_buf_r <= bus_req.wdata;
   end
   // Queued preamble or idle, and queued break
   always_ff @(posedge clk or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         idle_pend_r <= 1'b0;
         brk_pend_r <= 1'b0;
      end
      else
      begin
         if (wr_ctrl2 && bus_req.wdata[CTRL2_TX_EN] && !tx_en_r)
            idle_pend_r <= 1'b1;
         else if (load_idle)
            idle_pend_r <= 1'b0;
         if (wr_ctrl2 && bus_req.wdata[CTRL2_QBRK])
            brk_pend_r <= 1'b1;
         else if (load_brk)
            brk_pend_r <= qbrk_r;
      end
   end
   // Shifter: LSB leaves first, one bit per sixteen ticks
   always_ff @(posedge clk or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         shreg_r <= 11'h7ff;
         tx_sub_r <= 4'h0;
         tx_bits_r <= 4'h0;
         tx_busy_r <= 1'b0;
         tx_brk_r <= 1'b0;
      end
      else if (load_idle || load_brk || load_data)
      begin
         tx_busy_r <= 1'b1;
         tx_sub_r <= 4'h0;
         tx_brk_r <= load_brk;
         tx_bits_r <= load_brk ? brk_len : frame_len;
         if (load_data)
            shreg_r <= {1'b1, nine_bit_r ? t8_r : 1'b1, tx_buf_r, 1'b0};
         else
            shreg_r <= 11'h7ff;
      end
      else if (tx_busy_r && tick16)
      begin
         tx_sub_r <= tx_sub_r + 4'h1;
         if (tx_sub_r == TX_TICK_LAST)
         begin
            shreg_r <= {1'b1, shreg_r[10:1]};
            tx_bits_r <= tx_bits_r - 4'h1;
            if (tx_bits_r == 4'h1)
               tx_busy_r <= 1'b0;
         end
      end
   end
   // Vacant and all-done flags; a hardware set beats a software clear
   always_ff @(posedge clk or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         tx_buffer_vacant_r <= 1'b1;
         tc_r <= 1'b1;
         tx_arm_r <= 1'b0;
      end
      else
      begin
         if (rd_stat1)
            tx_arm_r <= tx_buffer_vacant_r || tc_r;
         else if (wr_data)
            tx_arm_r <= 1'b0;
         if (load_data)
            tx_buffer_vacant_r <= 1'b1;
         else if (wr_data && tx_arm_r)
            tx_buffer_vacant_r <= 1'b0;
         if (tx_last_end && tx_buffer_vacant_r && !idle_pend_r && !brk_pend_r)
            tc_r <= 1'b1;
         else if ((wr_data && tx_arm_r) || load_idle || load_brk || load_data)
            tc_r <= 1'b0;
      end
   end
   // Pin drive: idle high, break low, whole level flipped on request
   always_ff @(posedge clk or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         txd <= 1'b1;
         tx_oe <= 1'b0;
      end
      else
      begin
         txd <= (tx_busy_r ? (!tx_brk_r && shreg_r[0]) : 1'b1) ^ tx_flip_r;
         tx_oe <= tx_en_r || tx_busy_r || idle_pend_r || brk_pend_r;
      end
   end
   // ------------------------------------------------------------
   // Receiver
   // ------------------------------------------------------------
   astrc_rx_state_t rx_state_r;
   logic [2:0] hist_r, votes_r;
   logic [4:0] slot_r;
   logic [3:0] bit_idx_r, stop_idx;
   logic [8:0] rx_sh_r;
   logic [7:0] rx_buf_r, rx_new;
   logic rx_noise_r, rx_in, samp, maj, disagree, rx_done, rx_brk;
   logic rx_buffer_full_r, ovr_r, nf_r, fe_r, r8_r, rx_arm_r, clr_rx, rx_free;
   logic [2:0] vote3;
   assign rx_in = rxd ^ rx_flip_r;
   assign samp = tick16 && rx_en_r;
   assign stop_idx = nine_bit_r ? STOP_IDX_9 : STOP_IDX_8;
   assign vote3 = {votes_r[1:0], rx_in};
   assign maj = (vote3[0] && vote3[1]) || (vote3[0] && vote3[2]) || (vote3[1] && vote3[2]);
   assign disagree = (vote3 != 3'b000) && (vote3 != 3'b111);
   assign rx_done = samp && (rx_state_r == RX_FRAME) && (slot_r == SLOT_VOTE_C) && (bit_idx_r == stop_idx);
   assign rx_new = nine_bit_r ? rx_sh_r[7:0] : rx_sh_r[8:1];
   assign rx_brk = !maj && (rx_new == 8'h00);
   // Frame sampler; sixteen slots per bit counted from the falling edge
   always_ff @(posedge clk or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         rx_state_r <= RX_HUNT;
         hist_r <= 3'b000;
         votes_r <= 3'b000;
         slot_r <= SLOT_FIRST;
         bit_idx_r <= 4'h0;
         rx_sh_r <= 9'h000;
         rx_noise_r <= 1'b0;
      end
      else if (!rx_en_r)
      begin
         rx_state_r <= RX_HUNT;
         hist_r <= 3'b000;
      end
      else if (samp)
      begin
         hist_r <= {hist_r[1:0], rx_in};
         unique case (rx_state_r)
            RX_HUNT:
               if (hist_r == 3'b111 && !rx_in)
               begin
                  rx_state_r <= RX_START;
                  // The edge sample is slot one, so the next sample is slot two
                  slot_r <= SLOT_FIRST + 5'h01;
                  rx_noise_r <= 1'b0;
               end
            RX_START:
            begin
               slot_r <= slot_r + 5'h01;
               if (slot_r == SLOT_START_A || slot_r == SLOT_START_B || slot_r == SLOT_START_C)
                  votes_r <= vote3;
               if (slot_r == SLOT_START_C)
               begin
                  // Two or more zeros confirm a real start bit
                  if (!maj)
                  begin
                     rx_state_r <= RX_FRAME;
                     bit_idx_r <= 4'h0;
                     rx_noise_r <= disagree;
                  end
                  else
                     rx_state_r <= RX_HUNT;
               end
            end
            RX_FRAME:
            begin
               if (slot_r == SLOT_VOTE_A || slot_r == SLOT_VOTE_B)
                  votes_r <= vote3;
               if (slot_r == SLOT_VOTE_C)
               begin
                  rx_noise_r <= rx_noise_r || disagree;
                  if (bit_idx_r != 4'h0 && bit_idx_r != stop_idx)
                     rx_sh_r <= {maj, rx_sh_r[8:1]};
               end
               if (rx_done)
               begin
                  rx_state_r <= RX_HUNT;
                  // A framing error other than a break lets the next start in at once
                  hist_r <= rx_brk ? 3'b000 : 3'b111;
               end
               else if (hist_r[0] && !rx_in && bit_idx_r != 4'h0 && slot_r >= SLOT_LATE_EDGE)
               begin
                  slot_r <= SLOT_FIRST + 5'h01;
                  bit_idx_r <= bit_idx_r + 4'h1;
               end
               else if (hist_r[0] && !rx_in && bit_idx_r != 4'h0 && slot_r <= SLOT_START_A)
                  slot_r <= SLOT_FIRST + 5'h01;
               else if (slot_r == SLOT_LAST)
               begin
                  slot_r <= SLOT_FIRST;
                  bit_idx_r <= bit_idx_r + 4'h1;
               end
               else
                  slot_r <= slot_r + 5'h01;
            end
            default: rx_state_r <= RX_HUNT;
         endcase
      end
   end
   // Receive buffer and flags; a same-cycle clear frees the buffer first
   assign clr_rx = rd_dport && rx_arm_r;
   assign rx_free = !rx_buffer_full_r || clr_rx;
   always_ff @(posedge clk or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         rx_buffer_full_r <= 1'b0;
         ovr_r <= 1'b0;
         nf_r <= 1'b0;
         fe_r <= 1'b0;
         r8_r <= 1'b0;
         rx_buf_r <= 8'h00;
         rx_arm_r <= 1'b0;
      end
      else
      begin
         if (rd_stat1)
            rx_arm_r <= rx_buffer_full_r || ovr_r || nf_r || fe_r;
         else if (rd_dport)
            rx_arm_r <= 1'b0;
         if (clr_rx)
         begin
            rx_buffer_full_r <= 1'b0;
            ovr_r <= 1'b0;
            nf_r <= 1'b0;
            fe_r <= 1'b0;
         end
         if (rx_done && rx_free)
         begin
            rx_buf_r <= rx_new;
            r8_r <= rx_sh_r[8];
            rx_buffer_full_r <= 1'b1;
            nf_r <= rx_noise_r || disagree;
            fe_r <= !maj;
         end
         else if (rx_done)
            ovr_r <= 1'b1;
      end
   end
   // ------------------------------------------------------------
   // Read port
   // ------------------------------------------------------------
   logic [7:0] rd_mux;
   always_comb
   begin
      rd_mux = 8'h00;
      unique case (bus_req.addr)
         ADDR_BAUD_HI: rd_mux = {3'b000, baud_mod_r[12:8]};
         ADDR_BAUD_LO: rd_mux = baud_mod_r[7:0];
         ADDR_CTRL1: rd_mux[CTRL1_NINE_BIT] = nine_bit_r;
         ADDR_CTRL2:
         begin
            rd_mux[CTRL2_TX_EN] = tx_en_r;
            rd_mux[CTRL2_RX_EN] = rx_en_r;
            rd_mux[CTRL2_QBRK] = qbrk_r;
         end
         ADDR_STAT1:
         begin
            rd_mux[STAT1_TX_BUFFER_VACANT] = tx_buffer_vacant_r;
            rd_mux[STAT1_TC] = tc_r;
            rd_mux[STAT1_RX_BUFFER_FULL] = rx_buffer_full_r;
            rd_mux[STAT1_OVR] = ovr_r;
            rd_mux[STAT1_NF] = nf_r;
            rd_mux[STAT1_FE] = fe_r;
         end
         ADDR_STAT2:
         begin
            rd_mux[STAT2_RX_FLIP] = rx_flip_r;
            rd_mux[STAT2_LONG_BRK] = long_brk_r;
            rd_mux[STAT2_RX_ACTIVE] = rx_active;
         end
         ADDR_CTRL3:
         begin
            rd_mux[CTRL3_R8] = r8_r;
            rd_mux[CTRL3_T8] = t8_r;
            rd_mux[CTRL3_TX_FLIP] = tx_flip_r;
         end
         ADDR_DATA: rd_mux = rx_buf_r;
         default: rd_mux = 8'h00;
      endcase
   end
   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clk or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         rd_data <= 8'h00;
         rx_active <= 1'b0;
      end
      else
      begin
         rd_data <= bus_req.rd ? rd_mux : 8'h00;
         rx_active <= (rx_state_r != RX_HUNT);
      end
   end
   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n_r);
   property p_rd_data;
      rd_dport |=> rd_data == $past(rx_buf_r);
   endproperty
   a_rd_data: assert property (p_rd_data) else $error("data read did not return receive buffer");
   property p_rx_clear;
      (rd_dport && rx_arm_r && !rx_done) |=> !rx_buffer_full_r && !ovr_r;
   endproperty
   a_rx_clear: assert property (p_rx_clear) else $error("status then data read did not clear");
   property p_rx_load;
      (rx_done && !rx_buffer_full_r) |=> rx_buffer_full_r && rx_buf_r == $past(rx_new);
   endproperty
   a_rx_load: assert property (p_rx_load) else $error("received character not buffered");
   property p_overrun;
      (rx_done && rx_buffer_full_r && !clr_rx) |=> ovr_r && $stable(rx_buf_r);
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun not flagged or data overwritten");
   property p_tx_load;
      load_data |=> (tx_buffer_vacant_r && tx_busy_r && tx_bits_r == $past(frame_len)) ##1 (txd == $past(tx_flip_r));
   endproperty
   a_tx_load: assert property (p_tx_load) else $error("buffer not moved into shifter");
   property p_brk_len;
      load_brk |=> tx_brk_r && tx_bits_r == $past(brk_len);
   endproperty
   a_brk_len: assert property (p_brk_len) else $error("break length wrong");
   property p_idle_level;
      !tx_busy_r |=> txd != $past(tx_flip_r);
   endproperty
   a_idle_level: assert property (p_idle_level) else $error("idle level wrong");
   property p_hold_pin;
      (!tx_en_r && (tx_busy_r || idle_pend_r || brk_pend_r)) |=> tx_oe;
   endproperty
   a_hold_pin: assert property (p_hold_pin) else $error("pin released with work pending");
   property p_preamble;
      (idle_pend_r && tx_slot) |=> tx_busy_r && !tx_brk_r && shreg_r == 11'h7ff && tx_bits_r == $past(frame_len);
   endproperty
   a_preamble: assert property (p_preamble) else $error("queued idle frame not loaded whole");
   property p_all_done;
      (tx_last_end && tx_buffer_vacant_r && !idle_pend_r && !brk_pend_r) |=> tc_r && !tx_busy_r;
   endproperty
   a_all_done: assert property (p_all_done) else $error("all-done flag not set");
endmodule
`default_nettype wire

/* File: verif/astrc_remote.sv */
// Remote serial partner: sends frames on rxd and catches frames from txd.
// Assumes both ends share one bit period counted in bus clocks.
`timescale 1ns/1ps
`default_nettype none
module astrc_remote #(parameter int BIT = 32) (
   input wire logic clk, // Bus clock
   input wire logic txd, // Line from the core
   output var logic rxd // Line into the core
);
   logic [7:0] got; // Last byte caught
   int n_got = 0; // Frames caught
   initial rxd = 1'b1;
   // One frame plus a rest bit, so the core sees a clean idle after stop
   task automatic send(input logic [7:0] b);
      for (int i = 0; i < 11; i++)
      begin
         rxd <= (i == 0) ? 1'b0 : (i > 8) ? 1'b1 : b[i-1];
         repeat (BIT) @(posedge clk);
      end
   endtask
   // Mid-bit sampling after each falling edge; breaks count as frames too
   always
   begin
      @(negedge txd);
      repeat (BIT / 2) @(posedge clk);
      for (int i = 0; i < 9; i++)
      begin
         repeat (BIT) @(posedge clk);
         if (i < 8)
            got[i] = txd;
      end
      n_got++;
   end
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
// Bench for the serial core: register port, both serial directions, breaks.
// Assumes the remote model uses the same bit period as set here.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import astrc_pkg::*;
   localparam int BIT = 32; // Modulo 2, sixteen ticks a bit
   logic clk = 1'b0;
   logic resetn = 1'b0;
   astrc_bus_req_t bus_req = '0;
   logic [7:0] rd_data;
   logic rxd, txd, tx_oe, rx_active;
   logic [31:0] seed = 32'h000112e2;
   logic [7:0] b;
   int n_errors = 0;
   int checked = 0;
   int lead, len;
   always #5 clk = ~clk;
   astrc_core uut (.clk(clk), .resetn(resetn), .bus_req(bus_req), .rd_data(rd_data),
      .rxd(rxd), .txd(txd), .tx_oe(tx_oe), .rx_active(rx_active));
   astrc_remote #(.BIT(BIT)) rem (.clk(clk), .txd(txd), .rxd(rxd));
   // ---------------------------------------
   // Helpers
   // ---------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
   endfunction
   task automatic tally_and_finish;
      if (n_errors == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic bound(input logic hit);
      if (hit)
      begin
         n_errors++;
         tally_and_finish;
      end
   endtask
   // Strobes clear on a separate edge, so back-to-back calls never collide
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      bus_req <= '{a, v, 1'b1, 1'b0};
      @(posedge clk);
      bus_req <= '0;
      @(posedge clk);
   endtask
   task automatic rdc(input logic [2:0] a, input logic [7:0] m, input logic [7:0] exp);
      bus_req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk);
      bus_req <= '0;
      @(posedge clk);
      chk(rd_data & m, exp);
   endtask
   task automatic wait_got(input int n);
      for (int i = 0; i < 20 * BIT && rem.n_got < n; i++)
         @(posedge clk);
      bound(rem.n_got < n);
   endtask
   // Cycles high before the next low run, then length of that run
   task automatic low_run;
      lead = 0;
      len = 0;
      while (txd === 1'b1 && lead < 40 * BIT)
      begin
         @(posedge clk);
         lead++;
      end
      while (txd === 1'b0 && len < 40 * BIT)
      begin
         @(posedge clk);
         len++;
      end
      bound(lead >= 40 * BIT || len >= 40 * BIT);
   endtask
   // ---------------------------------------
   // Main sequence
   // ---------------------------------------
   initial
   begin
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      chk({6'h0, txd, tx_oe}, 8'h02);
      rdc(ADDR_STAT1, 8'hff, 8'hc0);
      wr(ADDR_BAUD_LO, 8'h02);
      wr(ADDR_CTRL2, 8'h0c);
      // Corner bytes first, then random ones
      for (int k = 0; k < 4; k++)
      begin
         seed = lfsr(seed);
         b = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : seed[7:0];
         rdc(ADDR_STAT1, 8'h80, 8'h80);
         wr(ADDR_DATA, b);
         wait_got(k + 1);
         chk(rem.got, b);
         repeat (BIT) @(posedge clk);
         rdc(ADDR_STAT1, 8'hff, 8'hc0);
      end
      // A data read alone must not clear the full flag
      seed = lfsr(seed);
      // Receiver must report activity mid-frame and drop it once the frame is done
      fork
         rem.send(seed[7:0]);
         begin
            repeat (4 * BIT) @(posedge clk);
            chk({7'h0, rx_active}, 8'h01);
         end
      join
      chk({7'h0, rx_active}, 8'h00);
      rdc(ADDR_DATA, 8'hff, seed[7:0]);
      rdc(ADDR_STAT1, 8'hff, 8'he0);
      rdc(ADDR_DATA, 8'hff, seed[7:0]);
      rdc(ADDR_STAT1, 8'hff, 8'hc0);
      rem.send(8'h5a);
      rem.send(8'h3c);
      rdc(ADDR_STAT1, 8'hff, 8'he8);
      rdc(ADDR_DATA, 8'hff, 8'h5a);
      rdc(ADDR_STAT1, 8'hff, 8'hc0);
      wr(ADDR_CTRL2, 8'h08);
      rem.send(8'ha5);
      rdc(ADDR_STAT1, 8'hff, 8'hc0);
      // Disable just after loading: the pin stays owned until the frame ends
      rdc(ADDR_STAT1, 8'h80, 8'h80);
      wr(ADDR_DATA, 8'h81);
      wr(ADDR_CTRL2, 8'h00);
      wait_got(5);
      chk({7'h0, tx_oe}, 8'h01);
      repeat (2 * BIT) @(posedge clk);
      chk({7'h0, tx_oe}, 8'h00);
      // Re-enable queues idle, which keeps the shifter busy past the break write
      for (int m = 0; m < 4; m++)
      begin
         wr(ADDR_CTRL1, m[0] ? 8'h10 : 8'h00);
         wr(ADDR_STAT2, m[1] ? 8'h04 : 8'h00);
         wr(ADDR_CTRL2, 8'h00);
         wr(ADDR_CTRL2, 8'h09);
         wr(ADDR_CTRL2, 8'h08);
         low_run;
         chk({7'h0, lead >= 10 * BIT - 8}, 8'h01);
         chk({7'h0, len == (10 + m % 2 + 3 * (m / 2)) * BIT}, 8'h01);
      end
      // Flipped polarity turns the idle level low
      wr(ADDR_CTRL3, 8'h10);
      @(posedge clk);
      chk({7'h0, txd}, 8'h00);
      tally_and_finish;
   end
endmodule
`default_nettype wire
